// ### verilog/local_mem_defines.svh
// Constants for the local memory port block
`ifndef LOCAL_MEM_DEFINES_SVH
`define LOCAL_MEM_DEFINES_SVH
`define DATA_ADDR_MSB 21
`define DATA_ADDR_LSB 3
`define INSTR_ADDR_MSB 21
`define INSTR_ADDR_LSB 2
`define BYTE_WE_NONE 4'h0
`define BYTE_WE_LSB 4'h1
`define BYTE_WE_MSB 4'h8
`define BYTE_WE_LOW_HALF 4'h3
`define BYTE_WE_WORD 4'hF
`define SIZE_CODE_ABSENT 5'h00
`define SIZE_CODE_MAX 5'h0D
`define DIR_WRITE 1'b1
`define DIR_READ 1'b0
`endif

// ### verilog/local_mem_pkg.sv
// Types shared by the local memory port block
package local_mem_pkg;
    typedef enum logic [1:0] {SIZE_BYTE, SIZE_HALF, SIZE_WORD} access_size_t;

    // Core-side request for one port
    typedef struct packed {
        logic valid;
        logic write;
        access_size_t size;
        logic [21:0] byte_addr;
        logic [31:0] wdata;
    } core_req_t;

    // Memory-side request driven on the pins
    typedef struct packed {
        logic select;
        logic write_not_read;
        logic [3:0] byte_we;
        logic [31:0] wdata;
    } mem_req_t;

    // Read answer back to the core
    typedef struct packed {
        logic valid;
        logic err;
        logic [31:0] rdata;
    } core_rsp_t;
endpackage : local_mem_pkg

// ### verilog/mem_port_channel.sv
// One local memory port: request register, stall and read capture
`timescale 1ns/1ps
`include "local_mem_defines.svh"
module mem_port_channel
    import local_mem_pkg::*;
#(
    parameter int ADDR_LSB = 3
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Gating
    input wire logic mem_enabled,
    input wire logic scan_shift_enable,
    // Core side
    input wire core_req_t core_req,
    output logic core_ready,
    output core_rsp_t core_rsp,
    // Memory side
    output mem_req_t mem_req,
    output logic [21:ADDR_LSB] mem_addr,
    input wire logic [31:0] mem_rdata,
    input wire logic mem_wait,
    input wire logic mem_err
);
    mem_req_t req_q, req_d;
    logic [21:ADDR_LSB] addr_q, addr_d;
    logic rd_pend_q, rd_pend_d;
    logic rd_due_q, rd_due_d;
    core_rsp_t rsp_q, rsp_d;
    logic [3:0] lanes;
    logic [1:0] boff;
    logic take;

    // Byte lane decode from size and low address bits
    always_comb
    begin
        boff = core_req.byte_addr[1:0];
        unique case (core_req.size)
            SIZE_BYTE: lanes = `BYTE_WE_LSB << boff;
            SIZE_HALF: lanes = boff[1] ? (`BYTE_WE_LOW_HALF << 2) : `BYTE_WE_LOW_HALF;
            default: lanes = `BYTE_WE_WORD;
        endcase
    end

    // Held request stays until the memory drops wait
    assign core_ready = !mem_wait;
    assign take = core_ready;

    always_comb
    begin
        req_d = req_q;
        addr_d = addr_q;
        rd_pend_d = rd_pend_q;
        rsp_d = rsp_q;
        rd_due_d = 1'b0;
        rsp_d.valid = 1'b0;
        // Read data and error stand in the cycle after the memory took the read
        if (rd_due_q)
        begin
            rsp_d.valid = 1'b1;
            rsp_d.rdata = mem_rdata;
            rsp_d.err = mem_err;
        end
        // The held read is taken by the memory at the first edge with wait low
        if (rd_pend_q && !mem_wait)
        begin
            rd_due_d = 1'b1;
            rd_pend_d = 1'b0;
        end
        if (take)
        begin
            req_d.select = core_req.valid && mem_enabled;
            req_d.write_not_read = core_req.write ? `DIR_WRITE : `DIR_READ;
            req_d.byte_we = (core_req.valid && core_req.write) ? lanes : `BYTE_WE_NONE;
            req_d.wdata = core_req.wdata;
            addr_d = core_req.byte_addr[21:ADDR_LSB];
            if (core_req.valid && mem_enabled && !core_req.write)
            begin
                rd_pend_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            req_q <= '0;
            addr_q <= '0;
            rd_pend_q <= 1'b0;
            rd_due_q <= 1'b0;
            rsp_q <= '0;
        end
        else
        begin
            req_q <= req_d;
            addr_q <= addr_d;
            rd_pend_q <= rd_pend_d;
            rd_due_q <= rd_due_d;
            rsp_q <= rsp_d;
        end
    end

    // Scan shift forces the chip select off to preserve contents
    always_comb
    begin
        mem_req = req_q;
        mem_req.select = req_q.select && !scan_shift_enable;
        mem_req.byte_we = req_q.select ? req_q.byte_we : `BYTE_WE_NONE;
    end
    assign mem_addr = addr_q;
    assign core_rsp = rsp_q;
endmodule : mem_port_channel

// ### verilog/local_mem_ports.sv
// Three local memory ports: two data ports and one instruction port
// Operation
// - Data port address is bits 21 to 3
// - Instruction port address is bits 21 to 2
// - Byte write enables select written byte lanes
// - Direction high for write; enables zero otherwise
// - First data port wait stalls and holds
// - Second data port wait stalls that port only
// - Instruction wait stalls fetch until released
// - Error sampled with read data marks failure
// - Memory enable captured at the first rising edge after reset
// - Outputs change and inputs sampled on rising edge, except combinational core ready, present flags and scan-gated chip selects
// - Scan enable forces chip selects inactive
`timescale 1ns/1ps
`include "local_mem_defines.svh"
module local_mem_ports
    import local_mem_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Configuration
    input wire logic local_mem_boot_enable,
    input wire logic scan_shift_enable,
    input wire logic [4:0] data_mem_size_code,
    input wire logic [4:0] instr_mem_size_code,
    // Status
    output logic local_mem_enabled,
    output logic data_mem_present,
    output logic instr_mem_present,
    // Core side, data port 0
    input wire core_req_t data0_core_req,
    output logic data0_core_ready,
    output core_rsp_t data0_core_rsp,
    // Core side, data port 1
    input wire core_req_t data1_core_req,
    output logic data1_core_ready,
    output core_rsp_t data1_core_rsp,
    // Core side, instruction port
    input wire core_req_t instr_core_req,
    output logic instr_core_ready,
    output core_rsp_t instr_core_rsp,
    // Data memory 0
    output logic [`DATA_ADDR_MSB:`DATA_ADDR_LSB] data_mem0_addr,
    output logic [31:0] data_mem0_wdata,
    output logic data_mem0_select,
    output logic [3:0] data_mem0_byte_we,
    output logic data_mem0_write_not_read,
    input wire logic [31:0] data_mem0_rdata,
    input wire logic data_mem0_wait,
    input wire logic data_mem0_err,
    // Data memory 1
    output logic [`DATA_ADDR_MSB:`DATA_ADDR_LSB] data_mem1_addr,
    output logic [31:0] data_mem1_wdata,
    output logic data_mem1_select,
    output logic [3:0] data_mem1_byte_we,
    output logic data_mem1_write_not_read,
    input wire logic [31:0] data_mem1_rdata,
    input wire logic data_mem1_wait,
    input wire logic data_mem1_err,
    // Instruction memory
    output logic [`INSTR_ADDR_MSB:`INSTR_ADDR_LSB] instr_mem_addr,
    output logic [31:0] instr_mem_wdata,
    output logic instr_mem_select,
    output logic [3:0] instr_mem_byte_we,
    output logic instr_mem_write_not_read,
    input wire logic [31:0] instr_mem_rdata,
    input wire logic instr_mem_wait,
    input wire logic instr_mem_err
);
    logic in_reset_q, in_reset_d;
    logic enable_q, enable_d;
    logic d_present, i_present;
    mem_req_t d0_req, d1_req, i_req;

    // Boot enable is sampled at the first rising edge after reset is released and frozen after that
    always_comb
    begin
        in_reset_d = 1'b0;
        enable_d = in_reset_q ? local_mem_boot_enable : enable_q;
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            in_reset_q <= 1'b1;
            enable_q <= 1'b0;
        end
        else
        begin
            in_reset_q <= in_reset_d;
            enable_q <= enable_d;
        end
    end

    // Absent memories never see a chip select
    assign d_present = (data_mem_size_code != `SIZE_CODE_ABSENT) && (data_mem_size_code <= `SIZE_CODE_MAX);
    assign i_present = (instr_mem_size_code != `SIZE_CODE_ABSENT) && (instr_mem_size_code <= `SIZE_CODE_MAX);
    assign local_mem_enabled = enable_q;
    assign data_mem_present = d_present;
    assign instr_mem_present = i_present;

    mem_port_channel #(.ADDR_LSB(`DATA_ADDR_LSB)) u_data0 (
        .clock(clock),
        .reset_n(reset_n),
        .mem_enabled(enable_q && d_present),
        .scan_shift_enable(scan_shift_enable),
        .core_req(data0_core_req),
        .core_ready(data0_core_ready),
        .core_rsp(data0_core_rsp),
        .mem_req(d0_req),
        .mem_addr(data_mem0_addr),
        .mem_rdata(data_mem0_rdata),
        .mem_wait(data_mem0_wait),
        .mem_err(data_mem0_err)
    );

    mem_port_channel #(.ADDR_LSB(`DATA_ADDR_LSB)) u_data1 (
        .clock(clock),
        .reset_n(reset_n),
        .mem_enabled(enable_q && d_present),
        .scan_shift_enable(scan_shift_enable),
        .core_req(data1_core_req),
        .core_ready(data1_core_ready),
        .core_rsp(data1_core_rsp),
        .mem_req(d1_req),
        .mem_addr(data_mem1_addr),
        .mem_rdata(data_mem1_rdata),
        .mem_wait(data_mem1_wait),
        .mem_err(data_mem1_err)
    );

    mem_port_channel #(.ADDR_LSB(`INSTR_ADDR_LSB)) u_instr (
        .clock(clock),
        .reset_n(reset_n),
        .mem_enabled(enable_q && i_present),
        .scan_shift_enable(scan_shift_enable),
        .core_req(instr_core_req),
        .core_ready(instr_core_ready),
        .core_rsp(instr_core_rsp),
        .mem_req(i_req),
        .mem_addr(instr_mem_addr),
        .mem_rdata(instr_mem_rdata),
        .mem_wait(instr_mem_wait),
        .mem_err(instr_mem_err)
    );

    assign data_mem0_wdata = d0_req.wdata;
    assign data_mem0_select = d0_req.select;
    assign data_mem0_byte_we = d0_req.byte_we;
    assign data_mem0_write_not_read = d0_req.write_not_read;
    assign data_mem1_wdata = d1_req.wdata;
    assign data_mem1_select = d1_req.select;
    assign data_mem1_byte_we = d1_req.byte_we;
    assign data_mem1_write_not_read = d1_req.write_not_read;
    assign instr_mem_wdata = i_req.wdata;
    assign instr_mem_select = i_req.select;
    assign instr_mem_byte_we = i_req.byte_we;
    assign instr_mem_write_not_read = i_req.write_not_read;
endmodule : local_mem_ports

// ### verification/local_mem_ports_properties.sv
// Pin timing checks for the local memory port block
`timescale 1ns/1ps
module local_mem_ports_properties
    import local_mem_pkg::*;
(
    // Clock and control
    input logic clock,
    input logic reset_n,
    input logic scan_shift_enable,
    input logic local_mem_enabled,
    // Data port 0
    input logic data0_core_ready,
    input core_rsp_t data0_core_rsp,
    input logic [21:3] data_mem0_addr,
    input logic data_mem0_select,
    input logic [3:0] data_mem0_byte_we,
    input logic data_mem0_write_not_read,
    input logic [31:0] data_mem0_rdata,
    input logic data_mem0_wait,
    input logic data_mem0_err,
    // Data port 1 and instruction port
    input logic [21:3] data_mem1_addr,
    input logic data_mem1_select,
    input logic data_mem1_wait,
    input logic [21:2] instr_mem_addr,
    input logic instr_mem_select,
    input logic instr_mem_wait
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    a_scan_off:
    assert property (scan_shift_enable |-> !(data_mem0_select | data_mem1_select | instr_mem_select))
        else $error("select during scan");
    a_read_no_we:
    assert property (!data_mem0_write_not_read |-> data_mem0_byte_we == 4'h0)
        else $error("byte enables on read");
    a_off_no_select:
    assert property (!local_mem_enabled |-> !data_mem0_select)
        else $error("select while disabled");
    a_ready_own_wait:
    assert property (data0_core_ready != data_mem0_wait)
        else $error("ready not from own wait");
    a_hold_data0:
    assert property (data_mem0_wait && data_mem0_select |=> data_mem0_select && $stable(data_mem0_addr))
        else $error("data0 request dropped in stall");
    a_hold_data1:
    assert property (data_mem1_wait && data_mem1_select |=> data_mem1_select && $stable(data_mem1_addr))
        else $error("data1 request dropped in stall");
    a_hold_instr:
    assert property (instr_mem_wait && instr_mem_select |=> instr_mem_select && $stable(instr_mem_addr))
        else $error("fetch dropped in stall");
    a_read_answer:
    assert property (data_mem0_select && !data_mem0_write_not_read && !data_mem0_wait ##1 1 |=>
        data0_core_rsp.valid && data0_core_rsp.rdata == $past(data_mem0_rdata)
        && data0_core_rsp.err == $past(data_mem0_err))
        else $error("read answer wrong");
endmodule : local_mem_ports_properties

// ### verification/sram_model.sv
// Synchronous RAM with commanded wait and read error
`timescale 1ns/1ps
module sram_model #(
    parameter int LSB = 3
)
(
    // Clock
    input logic clock,
    // Request
    input logic select,
    input logic write_not_read,
    input logic [3:0] byte_we,
    input logic [21:0] addr,
    input logic [31:0] wdata,
    // Answer
    output logic [31:0] rdata,
    output logic mem_wait,
    output logic err,
    // Commands
    input logic stall_cmd,
    input logic err_cmd
);
    logic [31:0] mem_q [256];
    assign mem_wait = stall_cmd;
    always_ff @(posedge clock)
    begin
        err <= 1'b0;
        // Idle read bus toggles between the last word and its complement
        rdata <= ~rdata;
        if (select && !mem_wait)
        begin
            for (int b = 0; b < 4; b++)
                if (write_not_read && byte_we[b])
                    mem_q[addr[LSB+7:LSB]][8*b+:8] <= wdata[8*b+:8];
            if (!write_not_read)
            begin
                rdata <= mem_q[addr[LSB+7:LSB]];
                err <= err_cmd;
            end
        end
    end
endmodule : sram_model

// ### verification/test_local_mem_ports.sv
// Bench for the local memory port block
`timescale 1ns/1ps
module test_local_mem_ports;
    import local_mem_pkg::*;
    logic clock = 0;
    logic reset_n = 0;
    logic boot_en = 1;
    logic scan = 0;
    logic [2:0] stall = 0;
    logic [2:0] err_cmd = 0;
    logic [4:0] d_size = 5'h0D;
    core_req_t req [3] = '{default: '0};
    wire core_rsp_t rsp [3];
    wire [2:0] rdy, sel, wnr, wt, er;
    wire [3:0] we [3];
    wire [31:0] wd [3], rd [3];
    wire [21:0] a [3];
    wire enabled, d_ok, i_ok;
    int mismatches = 0;
    int samples_checked = 0;
    local_mem_ports uut (.clock(clock), .reset_n(reset_n), .local_mem_boot_enable(boot_en),
        .scan_shift_enable(scan), .data_mem_size_code(d_size), .instr_mem_size_code(5'h0D),
        .local_mem_enabled(enabled), .data_mem_present(d_ok), .instr_mem_present(i_ok),
        .data0_core_req(req[0]), .data0_core_ready(rdy[0]), .data0_core_rsp(rsp[0]),
        .data1_core_req(req[1]), .data1_core_ready(rdy[1]), .data1_core_rsp(rsp[1]),
        .instr_core_req(req[2]), .instr_core_ready(rdy[2]), .instr_core_rsp(rsp[2]),
        .data_mem0_addr(a[0][21:3]), .data_mem0_wdata(wd[0]), .data_mem0_select(sel[0]),
        .data_mem0_byte_we(we[0]), .data_mem0_write_not_read(wnr[0]), .data_mem0_rdata(rd[0]),
        .data_mem0_wait(wt[0]), .data_mem0_err(er[0]),
        .data_mem1_addr(a[1][21:3]), .data_mem1_wdata(wd[1]), .data_mem1_select(sel[1]),
        .data_mem1_byte_we(we[1]), .data_mem1_write_not_read(wnr[1]), .data_mem1_rdata(rd[1]),
        .data_mem1_wait(wt[1]), .data_mem1_err(er[1]),
        .instr_mem_addr(a[2][21:2]), .instr_mem_wdata(wd[2]), .instr_mem_select(sel[2]),
        .instr_mem_byte_we(we[2]), .instr_mem_write_not_read(wnr[2]), .instr_mem_rdata(rd[2]),
        .instr_mem_wait(wt[2]), .instr_mem_err(er[2]));
    for (genvar i = 0; i < 3; i++)
    begin : g_mem
        sram_model #(.LSB(i == 2 ? 2 : 3)) mem (.clock(clock), .select(sel[i]), .write_not_read(wnr[i]),
            .byte_we(we[i]), .addr(a[i]), .wdata(wd[i]), .rdata(rd[i]), .mem_wait(wt[i]), .err(er[i]),
            .stall_cmd(stall[i]), .err_cmd(err_cmd[i]));
    end
    // Byte offset bits below each address bus are not pins
    assign a[0][2:0] = 3'h0;
    assign a[1][2:0] = 3'h0;
    assign a[2][1:0] = 2'h0;
    initial forever #10 clock = ~clock;
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    // One access; st holds the port's wait high for st cycles after it is taken
    task automatic op(input int p, input logic w, input access_size_t s, input logic [21:0] ad,
        input logic [31:0] d, input logic [3:0] we_x, input logic [31:0] x, input int st);
        int n = 0;
        int lsb = (p == 2) ? 2 : 3;
        @(posedge clock);
        req[p] <= '{1'b1, w, s, ad, d};
        do @(negedge clock); while (rdy[p] !== 1'b1 && ++n < 20);
        @(posedge clock);
        req[p].valid <= 1'b0;
        stall[p] <= (st != 0);
        @(negedge clock);
        chk("select", 1, sel[p]);
        chk("direction", w, wnr[p]);
        chk("byte enables", we_x, we[p]);
        chk("address", ad >> lsb, a[p] >> lsb);
        repeat (st) @(posedge clock);
        if (st != 0)
            stall[p] <= 1'b0;
        if (!w)
        begin
            n = 0;
            do @(negedge clock); while (rsp[p].valid !== 1'b1 && ++n < 10);
            chk("answer", 1, rsp[p].valid);
            chk("read data", x, rsp[p].rdata);
            chk("read error", err_cmd[p], rsp[p].err);
        end
    endtask : op
    task t_lanes;
        op(0, 1, SIZE_WORD, 22'h8, 32'h11223344, 4'hF, 0, 0);
        op(0, 1, SIZE_BYTE, 22'hB, 32'hAAAAAAAA, 4'h8, 0, 0);
        op(0, 1, SIZE_HALF, 22'h8, 32'hBBBBBBBB, 4'h3, 0, 0);
        op(0, 1, SIZE_BYTE, 22'h8, 32'hCCCCCCCC, 4'h1, 0, 0);
        op(0, 0, SIZE_WORD, 22'h8, 0, 4'h0, 32'hAA22BBCC, 0);
        op(0, 1, SIZE_HALF, 22'h1A, 32'hDDDDDDDD, 4'hC, 0, 0);
        chk("size decode", 1, d_ok & i_ok);
        @(posedge clock);
        d_size <= 5'h00;
        @(negedge clock);
        chk("absent size", 0, d_ok);
        @(posedge clock);
        d_size <= 5'h0E;
        @(negedge clock);
        chk("oversize code", 0, d_ok);
        @(posedge clock);
        d_size <= 5'h0D;
        $display("lanes test done");
    endtask : t_lanes
    task t_stall;
        op(0, 0, SIZE_WORD, 22'h8, 0, 4'h0, 32'hAA22BBCC, 3);
        op(2, 1, SIZE_WORD, 22'h3FFFFC, 32'h5A5A0F0F, 4'hF, 0, 2);
        op(2, 0, SIZE_WORD, 22'h3FFFFC, 0, 4'h0, 32'h5A5A0F0F, 4);
        @(posedge clock);
        stall[1] <= 1'b1;
        op(0, 0, SIZE_WORD, 22'h8, 0, 4'h0, 32'hAA22BBCC, 0);
        chk("stalled ready", 0, rdy[1]);
        @(posedge clock);
        stall[1] <= 1'b0;
        $display("stall test done");
    endtask : t_stall
    task t_error;
        op(1, 1, SIZE_WORD, 22'h10, 32'h0BADF00D, 4'hF, 0, 0);
        @(posedge clock);
        err_cmd[1] <= 1'b1;
        op(1, 0, SIZE_WORD, 22'h10, 0, 4'h0, 32'h0BADF00D, 1);
        @(posedge clock);
        err_cmd[1] <= 1'b0;
        op(1, 0, SIZE_WORD, 22'h10, 0, 4'h0, 32'h0BADF00D, 0);
        $display("error test done");
    endtask : t_error
    task t_scan_boot;
        @(posedge clock);
        scan <= 1'b1;
        req[0] <= '{1'b1, 1'b0, SIZE_WORD, 22'h8, 32'h0};
        @(posedge clock);
        req[0].valid <= 1'b0;
        @(negedge clock);
        chk("scan select", 0, sel[0]);
        repeat (3) @(posedge clock);
        scan <= 1'b0;
        reset_n <= 1'b0;
        boot_en <= 1'b0;
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        req[1] <= '{1'b1, 1'b0, SIZE_WORD, 22'h8, 32'h0};
        repeat (4) @(negedge clock) chk("disabled select", 0, sel[1]);
        chk("enabled flag", 0, enabled);
        $display("scan and boot test done");
    endtask : t_scan_boot
    task report_and_stop;
        $display("compared %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : report_and_stop
    initial
    begin
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        t_lanes;
        t_stall;
        t_error;
        t_scan_boot;
        report_and_stop;
    end
    initial
    begin
        #100000;
        mismatches++;
        report_and_stop;
    end
endmodule : test_local_mem_ports
bind local_mem_ports local_mem_ports_properties props (.*);
